// ==== design/tte_pkg.sv ====
`default_nettype none
package tte_pkg;

  // core clock and completion serialisation penalty
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam logic [1:0]  SER_EXTRA_CYC  = 2'h2;

  // handler base chosen by the prefix bit, and handler offsets
  localparam logic [31:0] VEC_BASE_HI    = 32'hfff0_0000;
  localparam logic [31:0] VEC_BASE_LO    = 32'h0000_0000;
  localparam logic [31:0] VEC_PROGRAM    = 32'h0000_0700;
  localparam logic [31:0] VEC_FP_UNAVAIL = 32'h0000_0800;
  localparam logic [31:0] VEC_DECR       = 32'h0000_0900;
  localparam logic [31:0] VEC_SYSCALL    = 32'h0000_0c00;
  localparam logic [31:0] VEC_TRACE      = 32'h0000_0d00;
  localparam logic [31:0] VEC_IABR       = 32'h0000_1300;
  localparam logic [31:0] VEC_EMUL       = 32'h0000_1600;

  // machine_state_reg bit positions (bit 0 is the least significant)
  localparam int MSR_POW  = 18;
  localparam int MSR_SHADOW_REGS_SELECT = 17;
  localparam int MSR_ILE  = 16;
  localparam int MSR_EE   = 15;
  localparam int MSR_PR   = 14;
  localparam int MSR_FP   = 13;
  localparam int MSR_ME   = 12;
  localparam int MSR_FE0  = 11;
  localparam int MSR_SE   = 10;
  localparam int MSR_BE   = 9;
  localparam int MSR_FE1  = 8;
  localparam int MSR_IP   = 6;
  localparam int MSR_IR   = 5;
  localparam int MSR_DR   = 4;
  localparam int MSR_RI   = 1;
  localparam int MSR_LE   = 0;

  // bits cleared on exception entry; HANDLER_ENDIAN_MODE, ME and IP are kept
  localparam logic [31:0] MSR_ENTRY_CLR  = 32'h0006_ef33;
  localparam logic [31:0] MSR_RESET      = 32'h0000_0040;
  // save_restore1 takes these machine-state bits, the rest are cleared
  localparam logic [31:0] SAVE_RESTORE1_COPY_MASK = 32'h0000_ffff;

  // fp_status_control fields: enables {v,o,u,z,x} and matching stickies
  localparam int FPS_EN_LSB = 3;
  localparam int FPS_ST_LSB = 24;
  localparam int FPS_FLAGS  = 5;

  // register byte offsets on the slave bus
  localparam logic [7:0] REG_MSR    = 8'h00;
  localparam logic [7:0] REG_SAVE_RESTORE0   = 8'h04;
  localparam logic [7:0] REG_SAVE_RESTORE1   = 8'h08;
  localparam logic [7:0] REG_FP_STATUS_CONTROL  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  typedef enum logic [3:0] {
    CAUSE_NONE    = 4'h0,
    CAUSE_IABR    = 4'h1,
    CAUSE_ILLEGAL = 4'h2,
    CAUSE_PRIV    = 4'h3,
    CAUSE_FPU     = 4'h4,
    CAUSE_EMUL    = 4'h5,
    CAUSE_SYSCALL = 4'h6,
    CAUSE_TRACE   = 4'h7,
    CAUSE_DECR    = 4'h8
  } tte_cause_e;

  // one instruction offered for completion
  typedef struct packed {
    logic                 valid;
    logic [31:0]          addr;
    logic [31:0]          next_addr;
    logic                 is_fp;
    logic                 is_fp_arith;
    logic                 is_emul;
    logic                 is_illegal;
    logic                 is_priv;
    logic                 is_sc;
    logic                 is_branch;
    logic                 is_rfi;
    logic                 is_isync;
    logic                 trap_taken;
    logic                 iabr_hit;
    logic [FPS_FLAGS-1:0] fp_flags;
  } tte_comp_s;

  // debug port controls
  typedef struct packed {
    logic soft_stop_en;
    logic hard_stop_en;
  } tte_dbg_s;

  // exception taken toward the fetch unit
  typedef struct packed {
    logic        valid;
    tte_cause_e  cause;
    logic [31:0] vector;
    logic        soft_stop;
    logic        hard_stop;
  } tte_exc_s;

endpackage
`default_nettype wire

// ==== design/tte_trap_trace.sv ====
`timescale 1ns/10ps
`default_nettype none
module tte_trap_trace
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // avalon-mm register slave
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // instruction completion
  input  wire tte_pkg::tte_comp_s comp,
  output logic                  comp_ready,
  // decrementer underflow pulse
  input  wire logic             dec_tick,
  // debug port controls
  input  wire tte_pkg::tte_dbg_s  dbg,
  // exception and stop outcome, architectural state
  output tte_pkg::tte_exc_s     exc,
  output logic [31:0]           machine_state_reg,
  output logic [31:0]           save_restore0,
  output logic [31:0]           save_restore1,
  output logic [31:0]           fp_status_control
);

  // byte-lane merge shared by every writable register
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // handler offset for each cause
  function automatic logic [31:0] vec_off(input tte_pkg::tte_cause_e c);
    logic [31:0] r;
    r = tte_pkg::VEC_PROGRAM;
    unique case (c)
      tte_pkg::CAUSE_IABR:    r = tte_pkg::VEC_IABR;
      tte_pkg::CAUSE_ILLEGAL: r = tte_pkg::VEC_PROGRAM;
      tte_pkg::CAUSE_PRIV:    r = tte_pkg::VEC_PROGRAM;
      tte_pkg::CAUSE_FPU:     r = tte_pkg::VEC_FP_UNAVAIL;
      tte_pkg::CAUSE_EMUL:    r = tte_pkg::VEC_EMUL;
      tte_pkg::CAUSE_SYSCALL: r = tte_pkg::VEC_SYSCALL;
      tte_pkg::CAUSE_TRACE:   r = tte_pkg::VEC_TRACE;
      tte_pkg::CAUSE_DECR:    r = tte_pkg::VEC_DECR;
      default:                r = tte_pkg::VEC_PROGRAM;
    endcase
    return r;
  endfunction

  logic [31:0]              msr_q;
  logic [31:0]              save_restore0_q;
  logic [31:0]              save_restore1_q;
  logic [31:0]              fp_status_control_q;
  logic                     dec_pend_q;
  tte_pkg::tte_cause_e      last_cause_q;
  logic [1:0]               ser_cnt_q;
  logic                     ack_q;
  logic [31:0]              rdata_q;
  tte_pkg::tte_exc_s        exc_q;

  logic [tte_pkg::FPS_FLAGS-1:0] fp_en;
  logic [tte_pkg::FPS_FLAGS-1:0] fp_sticky;
  logic [tte_pkg::FPS_FLAGS-1:0] new_sticky;
  logic                     fe_zero;
  logic                     fp_en_hit;
  logic                     ser_need;
  logic                     accept;
  logic                     ss_trace;
  logic                     br_trace;
  logic                     trace_cond;
  tte_pkg::tte_cause_e      cause;
  logic                     stop_soft;
  logic                     stop_hard;
  logic                     take;
  logic                     completed;
  logic [31:0]              save_addr;
  logic                     wr_fire;
  logic                     rd_fire;

  // fp status fields seen by completion
  assign fp_en      = fp_status_control_q[tte_pkg::FPS_EN_LSB +: tte_pkg::FPS_FLAGS];
  assign fp_sticky  = fp_status_control_q[tte_pkg::FPS_ST_LSB +: tte_pkg::FPS_FLAGS];
  assign new_sticky = comp.fp_flags & ~fp_en & ~fp_sticky;
  // unequal fe bits read as precise, so only both clear counts as off
  assign fe_zero    = ~msr_q[tte_pkg::MSR_FE0] & ~msr_q[tte_pkg::MSR_FE1];
  assign fp_en_hit  = comp.is_fp_arith & (|(comp.fp_flags & fp_en));

  // a first-time sticky change under disabled exceptions is serialised
  assign ser_need   = comp.valid & comp.is_fp_arith & fe_zero & ~fp_en_hit
                      & (|new_sticky) & msr_q[tte_pkg::MSR_FP];
  assign comp_ready = ~ser_need | (ser_cnt_q == tte_pkg::SER_EXTRA_CYC);
  assign accept     = comp.valid & comp_ready;

  // trace conditions; return and sync never single-step
  assign ss_trace   = msr_q[tte_pkg::MSR_SE] & ~comp.is_rfi & ~comp.is_isync;
  assign br_trace   = msr_q[tte_pkg::MSR_BE] & comp.is_branch;
  assign trace_cond = (ss_trace | br_trace) & ~comp.trap_taken;

  // fixed priority; each test is only reached when all above it are absent
  always_comb
  begin
    cause = tte_pkg::CAUSE_NONE;
    if (accept)
    begin
      if (comp.iabr_hit)
        cause = tte_pkg::CAUSE_IABR;
      else if (comp.is_illegal)
        cause = tte_pkg::CAUSE_ILLEGAL;
      else if (comp.is_priv & msr_q[tte_pkg::MSR_PR])
        cause = tte_pkg::CAUSE_PRIV;
      else if (comp.is_fp & ~msr_q[tte_pkg::MSR_FP])
        cause = tte_pkg::CAUSE_FPU;
      else if (comp.is_emul | fp_en_hit)
        cause = tte_pkg::CAUSE_EMUL;
      else if (comp.is_sc)
        cause = tte_pkg::CAUSE_SYSCALL;
      else if (comp.trap_taken)
        cause = tte_pkg::CAUSE_NONE; // trap handled by the program unit
      else if (trace_cond)
        cause = tte_pkg::CAUSE_TRACE;
      else if (dec_pend_q & msr_q[tte_pkg::MSR_EE])
        cause = tte_pkg::CAUSE_DECR;
    end
  end

  // debug port diverts breakpoint and trace into stops
  always_comb
  begin
    stop_soft = 1'b0;
    stop_hard = 1'b0;
    if (cause == tte_pkg::CAUSE_IABR || cause == tte_pkg::CAUSE_TRACE)
    begin
      if (dbg.soft_stop_en)
        stop_soft = 1'b1;
      else if (cause == tte_pkg::CAUSE_TRACE && br_trace && dbg.hard_stop_en)
        stop_hard = 1'b1;
    end
  end

  assign take      = (cause != tte_pkg::CAUSE_NONE) & ~stop_soft & ~stop_hard;
  // the instruction completed: no exception stopped it before completion
  assign completed = accept & (cause == tte_pkg::CAUSE_NONE || cause == tte_pkg::CAUSE_SYSCALL
                     || cause == tte_pkg::CAUSE_TRACE || cause == tte_pkg::CAUSE_DECR);
  // completed instructions resume after themselves, others re-execute
  assign save_addr = completed ? comp.next_addr : comp.addr;

  // bus handshake: one wait cycle, then the answer
  assign wr_fire         = avs_write & ack_q;
  assign rd_fire         = avs_read & ~ack_q;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;

  // bus acknowledge toggles off after each answered access
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  // read data captured in the wait cycle; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (rd_fire)
    begin
      unique case (avs_address)
        tte_pkg::REG_MSR:    rdata_q <= msr_q;
        tte_pkg::REG_SAVE_RESTORE0:   rdata_q <= save_restore0_q;
        tte_pkg::REG_SAVE_RESTORE1:   rdata_q <= save_restore1_q;
        tte_pkg::REG_FP_STATUS_CONTROL:  rdata_q <= fp_status_control_q;
        tte_pkg::REG_STATUS: rdata_q <= {27'h0000000, dec_pend_q, last_cause_q};
        default:             rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // serialisation stall counter, restarts after each accepted instruction
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ser_cnt_q <= 2'h0;
    else if (accept)
      ser_cnt_q <= 2'h0;
    else if (ser_need)
      ser_cnt_q <= ser_cnt_q + 2'h1;
  end

  // machine state: entry wins over rfi restore, which wins over software
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      msr_q <= tte_pkg::MSR_RESET;
    else if (take)
    begin
      // clears both trace enables and the fp modes, HANDLER_ENDIAN_MODE feeds LE
      msr_q <= (msr_q & ~tte_pkg::MSR_ENTRY_CLR)
               | {31'h00000000, msr_q[tte_pkg::MSR_ILE]};
    end
    else if (completed & comp.is_rfi)
      msr_q <= (msr_q & ~tte_pkg::SAVE_RESTORE1_COPY_MASK) | (save_restore1_q & tte_pkg::SAVE_RESTORE1_COPY_MASK);
    else if (wr_fire && avs_address == tte_pkg::REG_MSR)
      msr_q <= be_merge(msr_q, avs_writedata, avs_byteenable);
  end

  // save/restore pair loaded on every taken exception
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      save_restore0_q <= 32'h0000_0000;
      save_restore1_q <= 32'h0000_0000;
    end
    else if (take)
    begin
      save_restore0_q <= save_addr;
      save_restore1_q <= msr_q & tte_pkg::SAVE_RESTORE1_COPY_MASK;
    end
    else if (wr_fire)
    begin
      if (avs_address == tte_pkg::REG_SAVE_RESTORE0)
        save_restore0_q <= be_merge(save_restore0_q, avs_writedata, avs_byteenable);
      if (avs_address == tte_pkg::REG_SAVE_RESTORE1)
        save_restore1_q <= be_merge(save_restore1_q, avs_writedata, avs_byteenable);
    end
  end

  // fp status: completed fp ops or in stickies; a set beats a clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      fp_status_control_q <= 32'h0000_0000;
    else
    begin
      logic [31:0] base;
      logic [31:0] setb;
      base = fp_status_control_q;
      setb = 32'h0000_0000;
      if (wr_fire && avs_address == tte_pkg::REG_FP_STATUS_CONTROL)
        base = be_merge(fp_status_control_q, avs_writedata, avs_byteenable);
      // an enabling trap leaves status untouched
      if (completed & comp.is_fp_arith)
        setb[tte_pkg::FPS_ST_LSB +: tte_pkg::FPS_FLAGS] = comp.fp_flags;
      fp_status_control_q <= base | setb;
    end
  end

  // one pending decrementer request; a new tick in the take cycle survives
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      dec_pend_q <= 1'b0;
    else if (dec_tick)
      dec_pend_q <= 1'b1;
    else if (take && cause == tte_pkg::CAUSE_DECR)
      dec_pend_q <= 1'b0;
  end

  // last cause seen, for software inspection
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      last_cause_q <= tte_pkg::CAUSE_NONE;
    else if (cause != tte_pkg::CAUSE_NONE)
      last_cause_q <= cause;
  end

  // registered outcome: one-cycle pulses with vector held alongside
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_q.valid     <= 1'b0;
      exc_q.cause     <= tte_pkg::CAUSE_NONE;
      exc_q.vector    <= 32'h0000_0000;
      exc_q.soft_stop <= 1'b0;
      exc_q.hard_stop <= 1'b0;
    end
    else
    begin
      exc_q.valid     <= take;
      exc_q.soft_stop <= stop_soft;
      exc_q.hard_stop <= stop_hard;
      if (cause != tte_pkg::CAUSE_NONE)
      begin
        exc_q.cause  <= cause;
        exc_q.vector <= (msr_q[tte_pkg::MSR_IP] ? tte_pkg::VEC_BASE_HI : tte_pkg::VEC_BASE_LO)
                        | vec_off(cause);
      end
    end
  end

  // state outputs straight from their registers
  assign exc   = exc_q;
  assign machine_state_reg   = msr_q;
  assign save_restore0  = save_restore0_q;
  assign save_restore1  = save_restore1_q;
  assign fp_status_control = fp_status_control_q;

endmodule
`default_nettype wire

// ==== verif/tte_trap_trace_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module tte_trap_trace_bench;
  logic               clk_sys = 1'b0;
  logic               rst_n;
  logic [7:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  tte_pkg::tte_comp_s comp;
  tte_pkg::tte_comp_s c;
  logic               comp_ready;
  logic               dec_tick;
  tte_pkg::tte_dbg_s  dbg;
  tte_pkg::tte_exc_s  exc;
  logic [31:0]        machine_state_reg;
  logic [31:0]        save_restore0;
  logic [31:0]        save_restore1;
  logic [31:0]        fp_status_control;
  logic [31:0]        q;
  int                 n_fail;
  int                 checked;
  int                 s;
  logic [31:0]        vt [6] = '{tte_pkg::VEC_IABR, tte_pkg::VEC_PROGRAM,
    tte_pkg::VEC_PROGRAM, tte_pkg::VEC_FP_UNAVAIL, tte_pkg::VEC_EMUL, tte_pkg::VEC_SYSCALL};

  tte_trap_trace tte_trap_trace_inst
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .comp(comp),
    .comp_ready(comp_ready), .dec_tick(dec_tick), .dbg(dbg), .exc(exc), .machine_state_reg(machine_state_reg),
    .save_restore0(save_restore0), .save_restore1(save_restore1), .fp_status_control(fp_status_control)
  );

  // 50 MHz core clock
  always #10 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one register access; held until waitrequest is seen low before the edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      n_fail++;
    // the edge at which waitrequest stands low commits the access
    @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  function automatic tte_pkg::tte_comp_s mk(input logic [31:0] a);
    mk = '0;
    mk.valid = 1'b1;
    mk.addr = a;
    mk.next_addr = a + 32'h4;
  endfunction

  // offer one instruction, count held-off cycles, stop in the pulse cycle
  task automatic issue(input tte_pkg::tte_comp_s ci);
    s = 0;
    @(posedge clk_sys);
    comp <= ci;
    @(negedge clk_sys);
    while (comp_ready !== 1'b1 && s < 20)
    begin
      s++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    comp <= '0;
    @(negedge clk_sys);
  endtask

  task automatic took(input logic [3:0] k, input logic [31:0] v, input logic [31:0] r);
    chk({31'h0, exc.valid}, 32'h1);
    chk({28'h0, exc.cause}, {28'h0, k});
    chk(exc.vector, v);
    chk(save_restore0, r);
  endtask

  // valid, soft stop, hard stop as three bits
  task automatic quiet(input logic [2:0] e);
    chk({29'h0, exc.valid, exc.soft_stop, exc.hard_stop}, {29'h0, e});
  endtask

  function automatic logic [31:0] ent(input logic [31:0] m);
    ent = (m & ~tte_pkg::MSR_ENTRY_CLR) | {31'h0, m[tte_pkg::MSR_ILE]};
  endfunction

  task automatic t_reset;
    chk(machine_state_reg, tte_pkg::MSR_RESET);
    bus(1'b0, tte_pkg::REG_MSR, 32'h0);
    chk(q, 32'h0000_0040);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    bus(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
  endtask

  task automatic t_syscall;
    bus(1'b1, tte_pkg::REG_MSR, 32'h0007_bf73);
    c = mk(32'h0000_1000);
    c.is_sc = 1'b1;
    issue(c);
    took(4'h6, tte_pkg::VEC_BASE_HI | tte_pkg::VEC_SYSCALL, 32'h0000_1004);
    chk(save_restore1, 32'h0000_bf73);
    chk(machine_state_reg, ent(32'h0007_bf73));
  endtask

  // causes from iabr down to system call stacked, peeled one at a time from the top
  task automatic t_prio;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, tte_pkg::REG_MSR, 32'h0000_4440);
      c = mk(32'h0000_2000);
      c.iabr_hit = (i < 1);
      c.is_illegal = (i < 2);
      c.is_priv = (i < 3);
      c.is_fp = (i < 4);
      c.is_emul = (i < 5);
      c.is_sc = 1'b1;
      issue(c);
      took(i[3:0] + 4'h1, tte_pkg::VEC_BASE_HI | vt[i], (i < 5) ? c.addr : c.next_addr);
    end
  endtask

  task automatic t_trace;
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2400);
    c = mk(32'h0000_3000);
    issue(c);
    took(4'h7, tte_pkg::VEC_TRACE, 32'h0000_3004);
    chk(machine_state_reg, 32'h0);
    chk(save_restore1, 32'h0000_2400);
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2400);
      c = mk(32'h0000_3100);
      c.is_rfi = (k == 0);
      c.is_isync = (k == 1);
      c.trap_taken = (k == 2);
      issue(c);
      quiet(3'h0);
    end
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2200);
    c = mk(32'h0000_3200);
    issue(c);
    quiet(3'h0);
    c.is_branch = 1'b1;
    issue(c);
    took(4'h7, tte_pkg::VEC_TRACE, 32'h0000_3204);
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2200);
    dbg <= 2'b01;
    issue(c);
    quiet(3'h1);
    chk(machine_state_reg, 32'h0000_2200);
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2400);
    dbg <= 2'b10;
    issue(c);
    quiet(3'h2);
    c.iabr_hit = 1'b1;
    issue(c);
    quiet(3'h2);
    chk(machine_state_reg, 32'h0000_2400);
  endtask

  // two underflows while external interrupts are off must give one exception
  task automatic t_dec;
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2000);
    dbg <= 2'b00;
    repeat (2)
    begin
      @(posedge clk_sys);
      dec_tick <= 1'b1;
      @(posedge clk_sys);
      dec_tick <= 1'b0;
    end
    c = mk(32'h0000_4000);
    issue(c);
    quiet(3'h0);
    bus(1'b0, tte_pkg::REG_STATUS, 32'h0);
    chk({31'h0, q[4]}, 32'h1);
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_a000);
    issue(c);
    took(4'h8, tte_pkg::VEC_DECR, 32'h0000_4004);
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_a000);
    issue(c);
    quiet(3'h0);
  endtask

  task automatic t_fp;
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2000);
    bus(1'b1, tte_pkg::REG_FP_STATUS_CONTROL, 32'h0000_0008);
    c = mk(32'h0000_5000);
    c.is_fp = 1'b1;
    c.is_fp_arith = 1'b1;
    c.fp_flags = 5'h01;
    issue(c);
    took(4'h5, tte_pkg::VEC_EMUL, 32'h0000_5000);
    chk(fp_status_control, 32'h0000_0008);
    // software keeps every fp exception disabled in both registers
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2000);
    bus(1'b1, tte_pkg::REG_FP_STATUS_CONTROL, 32'h0);
    issue(c);
    chk(32'(s), 32'h2);
    chk(fp_status_control, 32'h0100_0000);
    issue(c);
    chk(32'(s), 32'h0);
    bus(1'b1, tte_pkg::REG_MSR, 32'h0000_2800);
    c.fp_flags = 5'h02;
    issue(c);
    chk(32'(s), 32'h0);
    chk(fp_status_control, 32'h0300_0000);
    quiet(3'h0);
  endtask

  task automatic report_and_stop;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, far beyond the roughly 135 cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    report_and_stop;
  end

  initial
  begin
    n_fail = 0;
    checked = 0;
    rst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    comp = '0;
    dec_tick = 1'b0;
    dbg = 2'b00;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_syscall;
    t_prio;
    t_trace;
    t_dec;
    t_fp;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ==== verif/tte_trap_trace_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module tte_trap_trace_props
(
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // completion and debug side
  input  wire tte_pkg::tte_comp_s comp,
  input  wire logic               comp_ready,
  input  wire tte_pkg::tte_dbg_s  dbg,
  // outcome and state
  input  wire tte_pkg::tte_exc_s  exc,
  input  wire logic [31:0]        machine_state_reg,
  input  wire logic [31:0]        save_restore0,
  input  wire logic [31:0]        save_restore1,
  input  wire logic [31:0]        fp_status_control
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // handler base; entry keeps the prefix bit, so the current value serves
  logic [31:0] base;
  assign base = machine_state_reg[tte_pkg::MSR_IP] ? tte_pkg::VEC_BASE_HI : tte_pkg::VEC_BASE_LO;

  // an exception of one cause seen in its pulse cycle
  sequence s_took(tte_pkg::tte_cause_e c);
    exc.valid && exc.cause == c;
  endsequence
  // first cycle of a held-off completion; the past term excludes the later held-off cycles
  sequence s_hold_start;
    comp.valid && !comp_ready && !$past(comp.valid && !comp_ready);
  endsequence

  property p_stall;
    s_hold_start |-> ##1 !comp_ready ##1 comp_ready;
  endproperty
  property p_emul;
    s_took(tte_pkg::CAUSE_EMUL) |-> $stable(fp_status_control) && exc.vector == (base | tte_pkg::VEC_EMUL);
  endproperty
  property p_fpu;
    s_took(tte_pkg::CAUSE_FPU) |-> !$past(machine_state_reg[tte_pkg::MSR_FP])
      && exc.vector == (base | tte_pkg::VEC_FP_UNAVAIL);
  endproperty
  property p_decr;
    s_took(tte_pkg::CAUSE_DECR) |-> $past(machine_state_reg[tte_pkg::MSR_EE])
      && exc.vector == (base | tte_pkg::VEC_DECR);
  endproperty
  property p_syscall;
    s_took(tte_pkg::CAUSE_SYSCALL) |-> save_restore0 == $past(comp.next_addr)
      && exc.vector == (base | tte_pkg::VEC_SYSCALL);
  endproperty
  property p_trace_vec;
    s_took(tte_pkg::CAUSE_TRACE) |-> save_restore0 == $past(comp.next_addr)
      && exc.vector == (base | tte_pkg::VEC_TRACE);
  endproperty
  property p_trace_excl;
    s_took(tte_pkg::CAUSE_TRACE) |-> !$past(comp.is_sc) && !$past(comp.trap_taken);
  endproperty
  property p_trace_clr;
    s_took(tte_pkg::CAUSE_TRACE) |-> !machine_state_reg[tte_pkg::MSR_SE] && !machine_state_reg[tte_pkg::MSR_BE];
  endproperty
  property p_save1;
    exc.valid |-> save_restore1 == ($past(machine_state_reg) & tte_pkg::SAVE_RESTORE1_COPY_MASK);
  endproperty
  property p_entry;
    exc.valid |-> machine_state_reg == (($past(machine_state_reg) & ~tte_pkg::MSR_ENTRY_CLR)
      | {31'h0, $past(machine_state_reg[tte_pkg::MSR_ILE])});
  endproperty
  property p_soft;
    exc.soft_stop |-> !exc.valid && $stable(machine_state_reg) && $past(dbg.soft_stop_en);
  endproperty

  a_stall:      assert property (p_stall) else $error("stall length wrong");
  a_emul:       assert property (p_emul) else $error("emulation trap wrong");
  a_fpu:        assert property (p_fpu) else $error("fp unavailable wrong");
  a_decr:       assert property (p_decr) else $error("decrementer wrong");
  a_syscall:    assert property (p_syscall) else $error("system call wrong");
  a_trace_vec:  assert property (p_trace_vec) else $error("trace vector wrong");
  a_trace_excl: assert property (p_trace_excl) else $error("trace after call");
  a_trace_clr:  assert property (p_trace_clr) else $error("trace enables kept");
  a_save1:      assert property (p_save1) else $error("saved state wrong");
  a_entry:      assert property (p_entry) else $error("entry state wrong");
  a_soft:       assert property (p_soft) else $error("soft stop wrong");
endmodule

bind tte_trap_trace tte_trap_trace_props tte_trap_trace_props_inst
(
  .clk_sys(clk_sys), .rst_n(rst_n), .comp(comp), .comp_ready(comp_ready), .dbg(dbg),
  .exc(exc), .machine_state_reg(machine_state_reg), .save_restore0(save_restore0), .save_restore1(save_restore1), .fp_status_control(fp_status_control)
);
`default_nettype wire
